// ==== rtl/irqsc_source_ctl.sv ====
`timescale 1ns/1ps
// What this block does
// [R01] Twelve master registers, five control registers left in slave mode
// [R02] Priority field bits 2-0, zero is highest
// [R03] Serial mask bit blocks serial interrupt
// [R04] Edge latch plus edge mode: rising edge triggers
// [R05] Rising edge latched once until serviced
// [R06] Level mode: high pin level requests
// [R07] Edge mode recognises low-to-high transition
// [R08] Each external line has its own mask
// [R09] Lines 0 and 1 hold special nested bit
// [R10] Lines 0 and 1 hold cascade bit
// [R11] DMA control holds mask and priority only
// [R12] Master mode: one shared timer control register
// [R13] Slave mode: three registers become timer controls
// [R14] Non-maskable interrupt sets freeze, halting DMA
// [R15] Return from handler clears freeze
// [R16] Status bits 2-0 show timer pending
// [R17] Status register resets to zero
// [R18] Grant needs global flag, unmasked, highest priority
// [R19] Mode register bit 14 selects slave mode
// [R20] In-service set on take, cleared by done write in master mode only
// [R21] Simultaneous ties resolved in fixed source order
// [R22] Reserved bits read zero, writes ignored
// [R23] Masked sources still record pending state
module irqsc_source_ctl
	import irqsc_pkg::*;
(
	input  wire logic                           core_clk,
	input  wire logic                           rst_n,
	input  wire logic                           clkEn,
	input  wire logic                           wb_cyc_i,
	input  wire logic                           wb_stb_i,
	input  wire logic                           wb_we_i,
	input  wire logic [irqsc_pkg::ADR_W-1:0]    wb_adr_i,
	input  wire logic [1:0]                     wb_sel_i,
	input  wire logic [irqsc_pkg::DAT_W-1:0]    wb_dat_i,
	output logic      [irqsc_pkg::DAT_W-1:0]    wb_dat_o,
	output logic                                wb_ack_o,
	input  wire logic [4:0]                     extRequest,
	input  wire logic                           serialRequest,
	input  wire logic [1:0]                     dmaRequest,
	input  wire logic [2:0]                     timerRequest,
	input  wire logic                           nmiEvent,
	input  wire logic                           handlerReturn,
	input  wire logic                           globalIntEnable,
	input  wire logic                           irqTaken,
	output logic                                irqRequest,
	output logic      [7:0]                     irqType,
	output logic                                transferFreeze,
	output logic      [1:0]                     cascadeEnable
);
	import irqsc_pkg::*;

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	logic [7:0]          ctlReg [0:CTL_NUM-1];
	logic                slaveMode;
	logic [SRC_NUM-1:0]  pending;
	logic [SRC_NUM-1:0]  inService;
	logic [SRC_NUM-1:0]  prevReq;
	logic [SRC_NUM-1:0]  rawReq;
	logic [SRC_NUM-1:0]  riseReq;
	logic [SRC_NUM-1:0]  isExt;
	logic [SRC_NUM-1:0]  srcMask;
	logic [SRC_NUM-1:0]  srcLevel;
	logic [SRC_NUM-1:0]  srcLatch;
	logic [SRC_NUM-1:0]  srcNested;
	logic [SRC_NUM-1:0]  active;
	logic [SRC_NUM-1:0]  pendSet;
	logic [SRC_NUM-1:0]  pendClr;
	logic [SRC_NUM-1:0]  svcSet;
	logic [SRC_NUM-1:0]  svcClr;
	logic [2:0]          srcPrio [0:SRC_NUM-1];
	logic [7:0]          srcCtl [0:SRC_NUM-1];
	logic [SRC_W-1:0]    winIdx;
	logic [SRC_W-1:0]    next_winIdx;
	logic                next_found;
	logic [2:0]          svcMinPrio;
	logic                svcAny;
	logic [IDX_W-1:0]    regIdx;
	logic                busReq;
	logic                busWr;
	logic                doneWr;
	logic [DAT_W-1:0]    next_rdData;

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	// Word index from the byte address
	assign regIdx = wb_adr_i[ADR_W-1:2];
	// New request seen while no answer is out
	assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// Writes take effect on the edge that raises ack
	assign busWr  = busReq & wb_we_i & clkEn;
	// Service-done write with the type in the low byte
	assign doneWr = busWr & wb_sel_i[0] & (regIdx == DONE_IDX) & ~slaveMode; // R20

	// One-cycle acknowledge for every address, mapped or not
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
		end else if (clkEn) begin
			wb_ack_o <= busReq;
		end
	end

	// ---------------------------------------------------------------
	// Mode register
	// ---------------------------------------------------------------
	// Master after reset; upper lane carries the mode bit
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			slaveMode <= 1'b0;
		end else if (busWr && wb_sel_i[1] && regIdx == MODE_IDX) begin
			slaveMode <= wb_dat_i[MODE_BIT]; // R19
		end
	end

	// ---------------------------------------------------------------
	// Source control registers
	// ---------------------------------------------------------------
	// Writes keep only implemented bits; entering slave mode clears
	// the three registers that turn into timer controls
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			for (int c = 0; c < CTL_NUM; c++) begin
				ctlReg[c] <= CTL_RST;
			end
		end else if (clkEn) begin
			for (int c = 0; c < CTL_NUM; c++) begin
				if (busWr && wb_sel_i[0] && regIdx == CTL_IDX[c]) begin
					if (slaveMode && (c == C_I1 || c == C_I0 || c == C_TM)) begin
						ctlReg[c] <= wb_dat_i[7:0] & PRIO_MASKW; // R13
					end else begin
						ctlReg[c] <= wb_dat_i[7:0] & CTL_WMASK[c]; // R02 R03 R08 R09 R10 R11 R12 R22
					end
				end else if (busWr && wb_sel_i[1] && regIdx == MODE_IDX && wb_dat_i[MODE_BIT]
					&& !slaveMode && (c == C_I1 || c == C_I0 || c == C_TM)) begin
					ctlReg[c] <= SLV_RST; // R13
				end
			end
		end
	end

	// Cascade selection for lines 0 and 1, master mode only
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cascadeEnable <= 2'b00;
		end else if (clkEn) begin
			cascadeEnable[0] <= ctlReg[C_I0][CAS_BIT] & ~slaveMode; // R10
			cascadeEnable[1] <= ctlReg[C_I0-1][CAS_BIT] & ~slaveMode; // R10
		end
	end

	// ---------------------------------------------------------------
	// Per-source view of the control fields
	// ---------------------------------------------------------------
	// Gather raw requests in tie-break order
	assign rawReq = {serialRequest, timerRequest[2], timerRequest[1], extRequest,
		dmaRequest[1], dmaRequest[0], timerRequest[0]};

	generate
		for (genvar s = 0; s < SRC_NUM; s++) begin : g_src
			// Slave mode moves timers 1 and 2 onto the line 0 and 1 registers
			if (s == S_TM1) begin : g_t1
				assign srcCtl[s] = slaveMode ? (ctlReg[C_I0] & PRIO_MASKW) : ctlReg[C_TM]; // R13
			end else if (s == S_TM2) begin : g_t2
				assign srcCtl[s] = slaveMode ? (ctlReg[C_I1] & PRIO_MASKW) : ctlReg[C_TM]; // R13
			end else begin : g_fix
				assign srcCtl[s] = ctlReg[SRC_CTL[s]]; // R12
			end
			assign isExt[s]     = (s >= S_EXT0) && (s <= S_EXT4);
			assign srcPrio[s]   = srcCtl[s][PRI_MSB:0]; // R02
			// External lines are out of use in slave mode
			assign srcMask[s]   = srcCtl[s][MASK_BIT] | (isExt[s] & slaveMode); // R03 R08 R11
			assign srcLevel[s]  = isExt[s] & srcCtl[s][LTS_BIT];
			assign srcLatch[s]  = isExt[s] & srcCtl[s][ETM_BIT];
			assign srcNested[s] = isExt[s] & srcCtl[s][SFN_BIT] & (s <= S_EXT0 + 1); // R09
			assign riseReq[s]   = rawReq[s] & ~prevReq[s]; // R07
			// A level line requests while high; others use the latch
			assign active[s]    = srcLevel[s] ? rawReq[s] : pending[s]; // R06
			// Internal sources latch their request level; edge lines the rising edge
			assign pendSet[s]   = isExt[s] ? (~srcLevel[s] & riseReq[s]) : rawReq[s]; // R04 R05
			// Unlatched edge mode lasts one cycle; taking the source clears it
			assign pendClr[s]   = (isExt[s] & ~srcLatch[s])
				| (irqTaken & irqRequest & (winIdx == SRC_W'(s))); // R05
			assign svcSet[s]    = irqTaken & irqRequest & (winIdx == SRC_W'(s)); // R20
			assign svcClr[s]    = doneWr & (wb_dat_i[7:0] == SRC_DONE[s]); // R20
		end
	endgenerate

	// ---------------------------------------------------------------
	// Request history and pending latches
	// ---------------------------------------------------------------
	// Previous request level for edge detection
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			prevReq <= '0;
		end else if (clkEn) begin
			prevReq <= rawReq;
		end
	end

	// Pending held even while masked; a new event beats a clear
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pending <= '0;
		end else if (clkEn) begin
			pending <= (pending & ~pendClr) | pendSet; // R05 R23
		end
	end

	// In-service bits; a take beats a done write in the same cycle
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			inService <= '0;
		end else if (clkEn) begin
			inService <= (inService & ~svcClr) | svcSet; // R20
		end
	end

	// ---------------------------------------------------------------
	// Priority resolution
	// ---------------------------------------------------------------
	// Highest priority currently in service
	always_comb begin
		svcMinPrio = PRIO_NONE;
		svcAny     = 1'b0;
		for (int s = 0; s < SRC_NUM; s++) begin
			if (inService[s] && (!svcAny || srcPrio[s] < svcMinPrio)) begin
				svcMinPrio = srcPrio[s];
				svcAny     = 1'b1;
			end
		end
	end

	// Pick the unmasked active source with the best code; lower
	// index wins a tie, nested lines may pre-empt their own level
	always_comb begin
		logic [2:0] bestPrio;
		logic       ok;
		bestPrio    = PRIO_NONE;
		next_found  = 1'b0;
		next_winIdx = '0;
		ok          = 1'b0;
		for (int s = 0; s < SRC_NUM; s++) begin
			ok = active[s] & ~srcMask[s]; // R18 R23
			if (svcAny) begin
				ok = ok & ((srcPrio[s] < svcMinPrio)
					| (srcNested[s] & (srcPrio[s] == svcMinPrio))); // R09 R18
			end
			if (ok && (!next_found || srcPrio[s] < bestPrio)) begin // R21
				bestPrio    = srcPrio[s];
				next_winIdx = SRC_W'(s);
				next_found  = 1'b1;
			end
		end
	end

	// Registered request and type toward the core
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			irqRequest <= 1'b0;
			irqType    <= 8'h00;
			winIdx     <= '0;
		end else if (clkEn) begin
			irqRequest <= next_found & globalIntEnable & ~(irqTaken & irqRequest); // R18
			irqType    <= SRC_TYPE[next_winIdx];
			winIdx     <= next_winIdx;
		end
	end

	// ---------------------------------------------------------------
	// Transfer freeze
	// ---------------------------------------------------------------
	// Set by a non-maskable event, cleared on return; set wins
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			transferFreeze <= 1'b0; // R17
		end else if (clkEn) begin
			if (nmiEvent) begin
				transferFreeze <= 1'b1; // R14
			end else if (handlerReturn) begin
				transferFreeze <= 1'b0; // R15
			end
		end
	end

	// ---------------------------------------------------------------
	// Read data
	// ---------------------------------------------------------------
	// Reserved bits and unmapped addresses read as zero
	always_comb begin
		next_rdData = '0;
		if (regIdx == STAT_IDX) begin
			next_rdData[FRZ_BIT] = transferFreeze; // R14
			next_rdData[2:0]     = {pending[S_TM2], pending[S_TM1], pending[S_TM0]}; // R16
		end else if (regIdx == MODE_IDX) begin
			next_rdData[MODE_BIT] = slaveMode;
		end else if (regIdx == DONE_IDX) begin
			next_rdData = '0;
		end else begin
			for (int c = 0; c < CTL_NUM; c++) begin
				if (regIdx == CTL_IDX[c]) begin
					next_rdData[7:0] = ctlReg[c]; // R01 R22
				end
			end
			// Slave mode exposes only its reduced set
			if (slaveMode && (regIdx == CTL_IDX[C_SER] || regIdx >= CTL_IDX[C_I4] - 8'h04)) begin
				next_rdData = '0; // R01
			end
		end
	end

	// Read data registered with the acknowledge
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wb_dat_o <= '0;
		end else if (clkEn && busReq) begin
			wb_dat_o <= next_rdData;
		end
	end

endmodule

// ==== inc/irqsc_pkg.sv ====
package irqsc_pkg;

	// ---------------------------------------------------------------
	// Bus geometry
	// ---------------------------------------------------------------
	localparam int          ADR_W      = 10;
	localparam int          DAT_W      = 16;
	localparam int          IDX_W      = 8;

	// ---------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ---------------------------------------------------------------
	localparam int          CTL_NUM    = 9;
	localparam logic [7:0]  CTL_IDX [0:CTL_NUM-1] = '{
		8'h44, 8'h40, 8'h3E, 8'h3C, 8'h3A, 8'h38, 8'h36, 8'h34, 8'h32};
	localparam logic [7:0]  CTL_WMASK [0:CTL_NUM-1] = '{
		8'h0F, 8'h9F, 8'h9F, 8'h9F, 8'hFF, 8'hFF, 8'h0F, 8'h0F, 8'h0F};
	localparam int          C_SER      = 0;
	localparam int          C_I4       = 1;
	localparam int          C_I1       = 4;
	localparam int          C_I0       = 5;
	localparam int          C_TM       = 8;
	localparam logic [7:0]  STAT_IDX   = 8'h30;
	localparam logic [7:0]  DONE_IDX   = 8'h22;
	localparam logic [7:0]  MODE_IDX   = 8'hFE;

	// ---------------------------------------------------------------
	// Reset values and field positions
	// ---------------------------------------------------------------
	localparam logic [7:0]  CTL_RST    = 8'h0F;
	localparam logic [7:0]  SLV_RST    = 8'h00;
	localparam logic [7:0]  PRIO_MASKW = 8'h0F;
	localparam logic [2:0]  PRIO_NONE  = 3'h7;
	localparam int          PRI_MSB    = 2;
	localparam int          MASK_BIT   = 3;
	localparam int          LTS_BIT    = 4;
	localparam int          CAS_BIT    = 5;
	localparam int          SFN_BIT    = 6;
	localparam int          ETM_BIT    = 7;
	localparam int          MODE_BIT   = 14;
	localparam int          FRZ_BIT    = 15;

	// ---------------------------------------------------------------
	// Sources in fixed tie-break order
	// ---------------------------------------------------------------
	localparam int          SRC_NUM    = 11;
	localparam int          SRC_W      = 4;
	localparam int          S_TM0      = 0;
	localparam int          S_EXT0     = 3;
	localparam int          S_EXT4     = 7;
	localparam int          S_TM1      = 8;
	localparam int          S_TM2      = 9;
	localparam logic [3:0]  SRC_CTL [0:SRC_NUM-1] = '{
		4'h8, 4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h8, 4'h8, 4'h0};
	localparam logic [7:0]  SRC_TYPE [0:SRC_NUM-1] = '{
		8'h08, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h12, 8'h13, 8'h14};
	localparam logic [7:0]  SRC_DONE [0:SRC_NUM-1] = '{
		8'h08, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h08, 8'h08, 8'h14};

endpackage

// ==== bench/irqsc_asserts.sv ====
`timescale 1ns/1ps
module irqsc_asserts
	import irqsc_pkg::*;
(
	input wire logic                         core_clk,
	input wire logic                         rst_n,
	input wire logic                         clkEn,
	input wire logic                         wb_cyc_i,
	input wire logic                         wb_stb_i,
	input wire logic                         wb_we_i,
	input wire logic [irqsc_pkg::ADR_W-1:0]  wb_adr_i,
	input wire logic [irqsc_pkg::DAT_W-1:0]  wb_dat_o,
	input wire logic                         wb_ack_o,
	input wire logic                         nmiEvent,
	input wire logic                         handlerReturn,
	input wire logic                         globalIntEnable,
	input wire logic                         irqTaken,
	input wire logic                         irqRequest,
	input wire logic [7:0]                   irqType,
	input wire logic                         transferFreeze
);
	import irqsc_pkg::*;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n || !clkEn);
	// Read answer of one word index
	logic [7:0] rdIdx;
	logic       rdAck;
	assign rdIdx = wb_adr_i[9:2];
	assign rdAck = wb_ack_o && !wb_we_i;
	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	property p_ackNext;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	property p_ackOnce;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	property p_statRsv;
		rdAck && rdIdx == STAT_IDX |-> wb_dat_o[14:3] == 12'h000;
	endproperty
	property p_dmaRsv;
		rdAck && (rdIdx == 8'h36 || rdIdx == 8'h34) |-> wb_dat_o[15:4] == 12'h000;
	endproperty
	property p_frzSet;
		nmiEvent |=> transferFreeze;
	endproperty
	property p_frzClr;
		handlerReturn && !nmiEvent |=> !transferFreeze;
	endproperty
	property p_gieOff;
		!globalIntEnable |=> !irqRequest;
	endproperty
	property p_takeDrop;
		irqRequest && irqTaken |=> !irqRequest;
	endproperty
	property p_type;
		irqRequest |-> irqType inside {SRC_TYPE};
	endproperty
	property p_rstOut;
		$rose(rst_n) |-> !irqRequest && !transferFreeze && !wb_ack_o;
	endproperty
	a_ackNext: assert property (p_ackNext) else $error("ack late");
	a_ackOnce: assert property (p_ackOnce) else $error("ack too long");
	a_statRsv: assert property (p_statRsv) else $error("status reserved set");
	a_dmaRsv: assert property (p_dmaRsv) else $error("dma reserved set");
	a_frzSet: assert property (p_frzSet) else $error("freeze not set");
	a_frzClr: assert property (p_frzClr) else $error("freeze not cleared");
	a_gieOff: assert property (p_gieOff) else $error("request while disabled");
	a_takeDrop: assert property (p_takeDrop) else $error("request kept");
	a_type: assert property (p_type) else $error("bad type");
	a_rstOut: assert property (p_rstOut) else $error("outputs after reset");
	c_freeze: cover property (nmiEvent ##1 transferFreeze);
	c_take: cover property (irqRequest && irqTaken);
	c_write: cover property (wb_ack_o && wb_we_i);
endmodule

bind irqsc_source_ctl irqsc_asserts u_chk (.core_clk, .rst_n, .clkEn, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .nmiEvent, .handlerReturn,
	.globalIntEnable, .irqTaken, .irqRequest, .irqType, .transferFreeze);

// ==== bench/irqsc_core_model.sv ====
`timescale 1ns/1ps
module irqsc_core_model (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        hold,
	input  wire logic        irqRequest,
	input  wire logic [7:0]  irqType,
	output logic             irqTaken,
	output logic      [7:0]  takenType,
	output int               takenCount
);
	// Takes a presented request at once unless held off
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			irqTaken   <= 1'b0;
			takenCount <= 0;
		end else begin
			irqTaken <= 1'b0;
			if (irqRequest && !irqTaken && !hold) begin
				irqTaken   <= 1'b1;
				takenType  <= irqType;
				takenCount <= takenCount + 1;
			end
		end
	end
endmodule

// ==== bench/test_irq_source_control_regs.sv ====
`timescale 1ns/1ps
module test_irq_source_control_regs;
	import irqsc_pkg::*;
	typedef struct {logic [7:0] idx; logic [15:0] wr; logic [15:0] rd;} irqsc_row_t;
	logic        core_clk, rst_n, clkEn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic        serialRequest, nmiEvent, handlerReturn, globalIntEnable, hold;
	logic        irqTaken, irqRequest, transferFreeze;
	logic [9:0]  wb_adr_i;
	logic [1:0]  wb_sel_i, dmaRequest, cascadeEnable;
	logic [15:0] wb_dat_i, wb_dat_o, q;
	logic [4:0]  extRequest;
	logic [2:0]  timerRequest;
	logic [7:0]  irqType, tType;
	int          tCount, fails, testsRun, cycles;
	logic [7:0]  slv [3] = '{8'h3A, 8'h38, 8'h32};
	irqsc_row_t  rows [11] = '{'{8'h44, 16'hFFFF, 16'h000F}, '{8'h40, 16'hFFFF, 16'h009F},
		'{8'h3E, 16'hFFFF, 16'h009F}, '{8'h3C, 16'hFFFF, 16'h009F}, '{8'h3A, 16'hFFFF, 16'h00FF},
		'{8'h38, 16'hFFFF, 16'h00FF}, '{8'h36, 16'hFFFF, 16'h000F}, '{8'h34, 16'hFFFF, 16'h000F},
		'{8'h32, 16'hFFFF, 16'h000F}, '{8'h30, 16'hFFFF, 16'h0000}, '{8'h50, 16'hFFFF, 16'h0000}};
	irqsc_source_ctl dut (.core_clk, .rst_n, .clkEn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .extRequest, .serialRequest, .dmaRequest,
		.timerRequest, .nmiEvent, .handlerReturn, .globalIntEnable, .irqTaken, .irqRequest,
		.irqType, .transferFreeze, .cascadeEnable);
	irqsc_core_model core (.core_clk, .rst_n, .hold, .irqRequest, .irqType, .irqTaken,
		.takenType(tType), .takenCount(tCount));
	// ---------------------------------------------------------------
	// Clock, timeout and tasks
	// ---------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Cuts a hang short
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			close_out();
		end
	end
	task automatic close_out;
		if (fails == 0 && testsRun > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		testsRun++;
		if (g !== e) begin
			fails++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	// One classic cycle, held until ack is sampled
	task automatic bus(input logic [7:0] i, input logic w, input logic [15:0] d);
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= {i, 2'b00};
		wb_dat_i <= d;
		do @(posedge core_clk); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	// Waits for the core to take, checks the type, then ends service
	task automatic serve(input logic [7:0] t, input logic [7:0] d);
		int n;
		n = tCount;
		while (tCount == n) @(posedge core_clk);
		chk("taken type", {8'h00, t}, {8'h00, tType});
		bus(DONE_IDX, 1'b1, {8'h00, d});
	endtask
	task automatic pulse(input logic [2:0] t, input logic [1:0] d, input logic s);
		@(posedge core_clk);
		timerRequest <= t;
		dmaRequest <= d;
		serialRequest <= s;
		@(posedge core_clk);
		timerRequest <= 3'h0;
		dmaRequest <= 2'h0;
		serialRequest <= 1'b0;
	endtask
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		{rst_n, wb_cyc_i, wb_stb_i, wb_we_i, serialRequest, nmiEvent, handlerReturn} = 7'h00;
		{globalIntEnable, hold, dmaRequest, timerRequest, extRequest} = 12'h000;
		{wb_adr_i, wb_dat_i, clkEn, wb_sel_i} = {10'h000, 16'h0000, 3'h7};
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		for (int k = 0; k < CTL_NUM; k++) begin
			bus(CTL_IDX[k], 1'b0, 16'h0000);
			chk("reset ctl", {8'h00, CTL_RST}, q);
		end
		bus(STAT_IDX, 1'b0, 16'h0000);
		chk("reset status", 16'h0000, q);
		foreach (rows[k]) begin
			bus(rows[k].idx, 1'b1, rows[k].wr);
			bus(rows[k].idx, 1'b0, 16'h0000);
			chk("readback", rows[k].rd, q);
		end
		chk("cascade", 16'h0003, {14'h0, cascadeEnable});
		globalIntEnable <= 1'b1;
		bus(8'h32, 1'b1, 16'h0003);
		bus(8'h34, 1'b1, 16'h0003);
		bus(8'h36, 1'b1, 16'h0003);
		pulse(3'h1, 2'h3, 1'b0);
		serve(8'h08, 8'h08);
		serve(8'h0A, 8'h0A);
		serve(8'h0B, 8'h0B);
		bus(8'h32, 1'b1, 16'h0006);
		bus(8'h36, 1'b1, 16'h0001);
		pulse(3'h1, 2'h2, 1'b0);
		serve(8'h0B, 8'h0B);
		serve(8'h08, 8'h08);
		bus(8'h44, 1'b1, 16'h0008);
		pulse(3'h0, 2'h0, 1'b1);
		repeat (5) @(posedge core_clk);
		chk("masked serial", 16'h0000, {15'h0, irqRequest});
		bus(8'h44, 1'b1, 16'h0000);
		serve(8'h14, 8'h14);
		globalIntEnable <= 1'b0;
		pulse(3'h0, 2'h1, 1'b0);
		repeat (4) @(posedge core_clk);
		chk("flag off", 16'h0000, {15'h0, irqRequest});
		globalIntEnable <= 1'b1;
		serve(8'h0A, 8'h0A);
		hold <= 1'b1;
		bus(8'h3C, 1'b1, 16'h0084);
		@(posedge core_clk);
		extRequest <= 5'h04;
		@(posedge core_clk);
		extRequest <= 5'h00;
		repeat (5) @(posedge core_clk);
		chk("latched edge", 16'h010E, {7'h0, irqRequest, irqType});
		extRequest <= 5'h04;
		hold <= 1'b0;
		serve(8'h0E, 8'h0E);
		repeat (5) @(posedge core_clk);
		chk("high after edge", 16'h0000, {15'h0, irqRequest});
		extRequest <= 5'h00;
		hold <= 1'b1;
		bus(8'h40, 1'b1, 16'h0012);
		extRequest <= 5'h10;
		repeat (4) @(posedge core_clk);
		chk("level high", 16'h0110, {7'h0, irqRequest, irqType});
		extRequest <= 5'h00;
		repeat (4) @(posedge core_clk);
		chk("level low", 16'h0000, {15'h0, irqRequest});
		nmiEvent <= 1'b1;
		pulse(3'h6, 2'h0, 1'b0);
		nmiEvent <= 1'b0;
		bus(STAT_IDX, 1'b0, 16'h0000);
		chk("status frozen", 16'h8006, q);
		chk("freeze out", 16'h0001, {15'h0, transferFreeze});
		handlerReturn <= 1'b1;
		@(posedge core_clk);
		handlerReturn <= 1'b0;
		bus(STAT_IDX, 1'b0, 16'h0000);
		chk("status thawed", 16'h0006, q);
		hold <= 1'b0;
		serve(8'h12, 8'h08);
		serve(8'h13, 8'h08);
		bus(STAT_IDX, 1'b0, 16'h0000);
		chk("status clear", 16'h0000, q);
		bus(MODE_IDX, 1'b1, 16'h4000);
		foreach (slv[k]) begin
			bus(slv[k], 1'b0, 16'h0000);
			chk("slave ctl", 16'h0000, q);
		end
		bus(8'h44, 1'b0, 16'h0000);
		chk("slave gone", 16'h0000, q);
		bus(8'h3C, 1'b0, 16'h0000);
		chk("slave gone 3C", 16'h0000, q);
		bus(8'h3A, 1'b1, 16'hFFFF);
		bus(8'h3A, 1'b0, 16'h0000);
		chk("slave timer", 16'h000F, q);
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		bus(8'h44, 1'b0, 16'h0000);
		chk("master again", 16'h000F, q);
		close_out();
	end
endmodule
